// *** logic/icl_pkg.sv ***
/*
  Package for the input current limit register block: command codes,
  field layout, reset values and the carrier structs.
  Assumes a word-level command port fed by an SMBus protocol engine
  that runs on the same clock as the block.
*/
package icl_pkg;

  // command codes
  localparam logic [7:0] ICL_CMD_APPLIED = 8'h22;
  localparam logic [7:0] ICL_CMD_CTRL = 8'h31;
  localparam logic [7:0] ICL_CMD_HOST = 8'h3F;

  // field layout
  localparam int ICL_FIELD_W = 7;
  localparam int ICL_FIELD_LSB = 8;
  localparam int ICL_FIELD_MSB = 14;
  localparam int ICL_RSVD_BIT = 15;
  localparam int ICL_HIZ_DIS_BIT = 7;
  localparam int ICL_STEP_MA = 50;

  // reset values
  localparam logic [15:0] ICL_LIMIT_RESET = 16'h4100;
  localparam logic [6:0] ICL_FIELD_DEFAULT = 7'h41;
  localparam logic [6:0] ICL_FIELD_FLOOR = 7'h01;
  localparam logic [7:0] ICL_LOW_BYTE = 8'h00;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } icl_cmd_t;

  typedef struct packed {
    logic [6:0] host;
    logic [6:0] appl;
    logic hiz_dis;
    logic adp_s1;
    logic adp_s2;
    logic adp_d;
    logic pin_s1;
    logic pin_s2;
    logic [15:0] rdata;
    logic rvalid;
    logic wr_err;
  } icl_state_t;

endpackage : icl_pkg

// *** logic/icl_regs.sv ***
/*
  Input current limit registers: host limit, applied limit and the
  limit pin disable bit, reached by word commands.
  Assumes the command port comes from logic on i_mclk; the adapter
  detect and limit pin levels come from pins and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - host writes a 16-bit word to command 3Fh to set the limit.
// - limit field spans 50 mA to 6350 mA in 50 mA steps.
// - bits 14..8 are binary weighted, 3200 mA down to 50 mA.
// - host limit register reads 4100h after reset, 3.25 A.
// - adapter removal reloads host limit with the 3.25 A default.
// - code 0 means 50 mA, applied and read back as such.
// - bit 15 reserved, reads zero; a write with it set is invalid.
// - low byte reads zero and written values there are ignored.
// - read-only 22h reports applied limit, same layout, reset 4100h.
// - optimizer changes only the applied register, never the host register.
// - bit 7 of 31h disables the limit pin function.
module icl_regs (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // word command port
  input wire icl_pkg::icl_cmd_t i_cmd,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_wr_err,
  // pins
  input wire logic i_adapter_present,
  input wire logic i_limit_highz_pin,
  // input power optimizer
  input wire logic i_opt_active,
  input wire logic [6:0] i_opt_code,
  // to regulation loop
  output logic [6:0] o_applied_code,
  output logic o_limit_pin_en,
  output logic o_hiz_req
);

  icl_pkg::icl_state_t st_r;
  icl_pkg::icl_state_t st_nxt;
  logic removal;
  logic host_wr;
  logic host_wr_ok;

  // code 0 is held as 0 but behaves and reads as 50 mA
  function automatic logic [6:0] floor_code(input logic [6:0] f);
    floor_code = (f == 7'h00) ? icl_pkg::ICL_FIELD_FLOOR : f;
  endfunction : floor_code

  function automatic logic [15:0] limit_word(input logic [6:0] f);
    limit_word = {1'b0, floor_code(f), icl_pkg::ICL_LOW_BYTE};
  endfunction : limit_word

  assign removal = st_r.adp_d & ~st_r.adp_s2;
  assign host_wr = i_cmd.valid & i_cmd.write & (i_cmd.code == icl_pkg::ICL_CMD_HOST);
  assign host_wr_ok = host_wr & ~i_cmd.wdata[icl_pkg::ICL_RSVD_BIT];

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.wr_err = 1'b0;
    // first stages feed only the second stages
    st_nxt.adp_s1 = i_adapter_present;
    st_nxt.adp_s2 = st_r.adp_s1;
    st_nxt.adp_d = st_r.adp_s2;
    st_nxt.pin_s1 = i_limit_highz_pin;
    st_nxt.pin_s2 = st_r.pin_s1;
    // removal outranks a write in the same cycle so the safe default lands
    if (removal) begin
      st_nxt.host = icl_pkg::ICL_FIELD_DEFAULT;
    end else if (host_wr_ok) begin
      st_nxt.host = i_cmd.wdata[icl_pkg::ICL_FIELD_MSB:icl_pkg::ICL_FIELD_LSB];
    end
    // optimizer result goes to the applied copy only
    if (i_opt_active) begin
      st_nxt.appl = i_opt_code;
    end else begin
      st_nxt.appl = st_r.host;
    end
    if (i_cmd.valid && i_cmd.write) begin
      case (i_cmd.code)
        icl_pkg::ICL_CMD_HOST: st_nxt.wr_err = i_cmd.wdata[icl_pkg::ICL_RSVD_BIT];
        icl_pkg::ICL_CMD_CTRL: st_nxt.hiz_dis = i_cmd.wdata[icl_pkg::ICL_HIZ_DIS_BIT];
        default: st_nxt.wr_err = 1'b1;
      endcase
    end
    if (i_cmd.valid && !i_cmd.write) begin
      st_nxt.rvalid = 1'b1;
      case (i_cmd.code)
        icl_pkg::ICL_CMD_HOST: st_nxt.rdata = limit_word(st_r.host);
        icl_pkg::ICL_CMD_APPLIED: st_nxt.rdata = limit_word(st_r.appl);
        icl_pkg::ICL_CMD_CTRL: st_nxt.rdata = {8'h00, st_r.hiz_dis, 7'h00};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      // adapter chain resets low: a removal needs a seen high first, so no false reload
      // pin chain resets to its idle high level, so no false high-impedance request
      st_r <= '{host: icl_pkg::ICL_FIELD_DEFAULT, appl: icl_pkg::ICL_FIELD_DEFAULT, hiz_dis: 1'b0,
                adp_s1: 1'b0, adp_s2: 1'b0, adp_d: 1'b0, pin_s1: 1'b1, pin_s2: 1'b1,
                rdata: 16'h0000, rvalid: 1'b0, wr_err: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata = st_r.rdata;
  assign o_rvalid = st_r.rvalid;
  assign o_wr_err = st_r.wr_err;
  assign o_applied_code = floor_code(st_r.appl);
  // pin held low requests high impedance unless software masked it
  assign o_limit_pin_en = ~st_r.hiz_dis;
  assign o_hiz_req = ~st_r.hiz_dis & ~st_r.pin_s2;

  // helper for the after-reset check
  logic seen_r;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  // pins are watched through their synced stages, never raw
  chk_reset_default: assert property (!seen_r |-> st_r.host == icl_pkg::ICL_FIELD_DEFAULT
      && st_r.appl == icl_pkg::ICL_FIELD_DEFAULT)
    else $error("limit registers not at default after reset");

  chk_host_write_take: assert property (host_wr_ok && !removal
      |=> st_r.host == $past(i_cmd.wdata[icl_pkg::ICL_FIELD_MSB:icl_pkg::ICL_FIELD_LSB]) && !o_wr_err)
    else $error("valid host limit write not taken");

  chk_invalid_write_drop: assert property (host_wr && i_cmd.wdata[icl_pkg::ICL_RSVD_BIT] && !removal
      |=> $stable(st_r.host) && o_wr_err)
    else $error("write with reserved bit changed the limit");

  chk_removal_reload: assert property (st_r.adp_d && !st_r.adp_s2
      |=> st_r.host == icl_pkg::ICL_FIELD_DEFAULT)
    else $error("adapter removal did not reload default");

  chk_removal_priority: assert property (st_r.adp_d && !st_r.adp_s2 && host_wr_ok
      |=> st_r.host == icl_pkg::ICL_FIELD_DEFAULT)
    else $error("host write beat adapter removal");

  chk_read_layout: assert property (o_rvalid && $past(i_cmd.code) != icl_pkg::ICL_CMD_CTRL
      |-> o_rdata[icl_pkg::ICL_RSVD_BIT] == 1'b0 && o_rdata[icl_pkg::ICL_FIELD_LSB-1:0] == icl_pkg::ICL_LOW_BYTE)
    else $error("reserved read bits not zero");

  chk_zero_code_read: assert property (i_cmd.valid && !i_cmd.write && i_cmd.code == icl_pkg::ICL_CMD_HOST
      && st_r.host == 7'h00
      |=> o_rvalid && o_rdata == {1'b0, icl_pkg::ICL_FIELD_FLOOR, icl_pkg::ICL_LOW_BYTE})
    else $error("code 0 did not read back as 50 mA");

  // output code is never zero and differs from the register only at code 0
  chk_applied_floor: assert property (o_applied_code != 7'h00
      && (st_r.appl == 7'h00 || o_applied_code == st_r.appl))
    else $error("applied limit below 50 mA");

  chk_opt_floor: assert property (i_opt_active && i_opt_code == 7'h00
      |=> o_applied_code == icl_pkg::ICL_FIELD_FLOOR)
    else $error("optimizer code 0 not applied as 50 mA");

  chk_mirror: assert property (!i_opt_active ##1 !i_opt_active
      |-> st_r.appl == $past(st_r.host))
    else $error("applied limit not following host field");

  chk_opt_no_host: assert property (i_opt_active && !host_wr && !removal
      |=> $stable(st_r.host) && st_r.appl == $past(i_opt_code))
    else $error("optimizer result misplaced");

  chk_applied_read: assert property (i_cmd.valid && !i_cmd.write
      && i_cmd.code == icl_pkg::ICL_CMD_APPLIED
      |=> o_rvalid && o_rdata[icl_pkg::ICL_FIELD_MSB:icl_pkg::ICL_FIELD_LSB]
      == ($past(st_r.appl) == 7'h00 ? icl_pkg::ICL_FIELD_FLOOR : $past(st_r.appl)))
    else $error("applied limit read wrong");

  // read-only copy: a write there is refused and the host copy stays
  chk_applied_write_refused: assert property (i_cmd.valid && i_cmd.write
      && i_cmd.code == icl_pkg::ICL_CMD_APPLIED && !removal
      |=> o_wr_err && $stable(st_r.host))
    else $error("write to read-only applied limit accepted");

  chk_unmapped_read: assert property (i_cmd.valid && !i_cmd.write && i_cmd.code != icl_pkg::ICL_CMD_HOST
      && i_cmd.code != icl_pkg::ICL_CMD_APPLIED && i_cmd.code != icl_pkg::ICL_CMD_CTRL
      |=> o_rvalid && o_rdata == 16'h0000)
    else $error("unmapped read not zero");

  chk_read_answer: assert property (o_rvalid |-> $past(i_cmd.valid && !i_cmd.write))
    else $error("read answer without a read");

  chk_rdata_hold: assert property (!o_rvalid |-> $stable(o_rdata))
    else $error("read word changed without a read");

  chk_error_cause: assert property (o_wr_err |-> $past(i_cmd.valid && i_cmd.write))
    else $error("write error without a write");

  chk_ctrl_write: assert property (i_cmd.valid && i_cmd.write && i_cmd.code == icl_pkg::ICL_CMD_CTRL
      |=> st_r.hiz_dis == $past(i_cmd.wdata[icl_pkg::ICL_HIZ_DIS_BIT]) && !o_wr_err)
    else $error("limit pin disable bit not taken");

  chk_ctrl_read: assert property (i_cmd.valid && !i_cmd.write && i_cmd.code == icl_pkg::ICL_CMD_CTRL
      |=> o_rvalid && o_rdata == {8'h00, $past(st_r.hiz_dis), 7'h00})
    else $error("limit pin disable bit read wrong");

  chk_pin_gate: assert property (st_r.hiz_dis |-> !o_hiz_req && !o_limit_pin_en)
    else $error("disabled limit pin still acted");

  chk_pin_follow: assert property (!st_r.hiz_dis |-> o_limit_pin_en && o_hiz_req == !st_r.pin_s2)
    else $error("enabled limit pin not followed");

endmodule : icl_regs

`default_nettype wire

// *** verif/icl_host.sv ***
/*
  host model: issues one word command per call of xfer.
  assumes the bench owns the clock and calls xfer from its sequence.
*/
`timescale 1ns/1ns
`default_nettype none
module icl_host (
  // clock
  input wire logic i_mclk,
  // command out
  output var icl_pkg::icl_cmd_t o_cmd
);
  initial o_cmd = '0;
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    @(negedge i_mclk);
    o_cmd <= '{1'b1, wr, code, wd};
    @(negedge i_mclk);
    // released bus shows the inverse so stale data cannot pass
    o_cmd <= '{1'b0, ~wr, ~code, ~wd};
  endtask : xfer
endmodule : icl_host
`default_nettype wire

// *** verif/tb.sv ***
/*
  bench for icl_regs driven through the host model.
  assumes icl_pkg and icl_host are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, rstn, adp, pin, opt, rv, we, pen, hiz;
  logic [6:0] optc, f, ac;
  logic [15:0] rd;
  icl_pkg::icl_cmd_t cmd;
  int error_cnt, cmp_count;
  icl_host host (.i_mclk(clk), .o_cmd(cmd));
  icl_regs uut (.i_mclk(clk), .i_resetn(rstn), .i_cmd(cmd), .o_rdata(rd), .o_rvalid(rv),
    .o_wr_err(we), .i_adapter_present(adp), .i_limit_highz_pin(pin), .i_opt_active(opt),
    .i_opt_code(optc), .o_applied_code(ac), .o_limit_pin_en(pen), .o_hiz_req(hiz));
  function automatic logic [15:0] word(input logic [6:0] v);
    return {1'b0, (v == 7'h00) ? icl_pkg::ICL_FIELD_FLOOR : v, icl_pkg::ICL_LOW_BYTE};
  endfunction : word
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    host.xfer(1'b0, c, 16'h0000);
    chk({rv, rd}, {1'b1, e});
  endtask : rdc
  task automatic wrc(input logic [7:0] c, input logic [15:0] d, input logic bad);
    host.xfer(1'b1, c, d);
    chk({16'h0000, we}, {16'h0000, bad});
  endtask : wrc
  task report_and_stop;
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #5000000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rstn, opt, optc} = '0;
    {adp, pin} = 2'h3;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(32'h10C0));
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    rdc(icl_pkg::ICL_CMD_HOST, 16'h4100);
    rdc(icl_pkg::ICL_CMD_APPLIED, 16'h4100);
    for (int i = 0; i < 12; i++) begin
      f = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
      wrc(icl_pkg::ICL_CMD_HOST, {1'b0, f, 8'($urandom)}, 1'b0);
      rdc(icl_pkg::ICL_CMD_HOST, word(f));
      rdc(icl_pkg::ICL_CMD_APPLIED, word(f));
      chk({10'h000, ac}, {10'h000, (f == 7'h00) ? 7'h01 : f});
    end
    wrc(icl_pkg::ICL_CMD_HOST, 16'hC000, 1'b1);
    wrc(icl_pkg::ICL_CMD_APPLIED, 16'h0A00, 1'b1);
    rdc(8'h00, 16'h0000);
    rdc(icl_pkg::ICL_CMD_HOST, word(f));
    // optimizer takes the applied limit, host copy must stay
    optc = 7'($urandom);
    opt = 1'b1;
    rdc(icl_pkg::ICL_CMD_APPLIED, word(optc));
    rdc(icl_pkg::ICL_CMD_HOST, word(f));
    optc = 7'h00;
    rdc(icl_pkg::ICL_CMD_APPLIED, word(optc));
    chk({10'h000, ac}, {10'h000, icl_pkg::ICL_FIELD_FLOOR});
    opt = 1'b0;
    // move off the default so the reload is visible
    wrc(icl_pkg::ICL_CMD_HOST, 16'h0A00, 1'b0);
    adp = 1'b0;
    repeat (8) @(negedge clk);
    adp = 1'b1;
    rdc(icl_pkg::ICL_CMD_HOST, icl_pkg::ICL_LIMIT_RESET);
    rdc(icl_pkg::ICL_CMD_APPLIED, icl_pkg::ICL_LIMIT_RESET);
    pin = 1'b0;
    wrc(icl_pkg::ICL_CMD_CTRL, 16'h0080, 1'b0);
    repeat (4) @(negedge clk);
    chk({15'h0000, pen, hiz}, 17'h00000);
    rdc(icl_pkg::ICL_CMD_CTRL, 16'h0080);
    wrc(icl_pkg::ICL_CMD_CTRL, 16'h0000, 1'b0);
    repeat (4) @(negedge clk);
    chk({15'h0000, pen, hiz}, 17'h00003);
    // mid-run reset must restore both limits and clear the pin mask
    wrc(icl_pkg::ICL_CMD_HOST, 16'h0A00, 1'b0);
    wrc(icl_pkg::ICL_CMD_CTRL, 16'h0080, 1'b0);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rdc(icl_pkg::ICL_CMD_HOST, icl_pkg::ICL_LIMIT_RESET);
    rdc(icl_pkg::ICL_CMD_APPLIED, icl_pkg::ICL_LIMIT_RESET);
    pin = 1'b1;
    repeat (4) @(negedge clk);
    chk({15'h0000, pen, hiz}, 17'h00002);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
